// file: dv/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, sys_rst_i = 1, wr_i = 0, rd_i = 0, stop_mode_i = 0, cpu_on_subclk_i = 0, wdt_irq_mask_i = 0;
  logic [15:0] addr_i = 0;
  logic [7:0] wdata_i = 0, wbit_en_i = 0, rdata_o;
  logic wdt_interval_irq_o, wdt_nmi_req_o, wdt_reset_req_o, running_o, wdt_irq_flag_i;
  logic [1:0] mode_o;
  int n_errors = 0, check_count = 0, n;
  wdtit_top wdtit_top_inst (.*);
  wdtit_cpu_model wdtit_cpu_model_inst (.clk_i, .sys_rst_i, .irq_i(wdt_interval_irq_o),
    .nmi_i(wdt_nmi_req_o), .flag_o(wdt_irq_flag_i));
  initial forever #2.5 clk_i = ~clk_i;
  task automatic chk(input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d, e);
    @(negedge clk_i);
    {addr_i, wdata_i, wbit_en_i, wr_i} = {a, d, e, 1'b1};
    @(negedge clk_i);
    wr_i = 0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] x);
    @(negedge clk_i);
    {addr_i, rd_i} = {a, 1'b1};
    @(negedge clk_i);
    rd_i = 0;
    chk(rdata_o, x);
  endtask
  task automatic wt(input int lim);
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (!(wdt_interval_irq_o | wdt_nmi_req_o | wdt_reset_req_o) && n < lim);
  endtask
  task automatic rst;
    sys_rst_i = 1;
    repeat (6) @(negedge clk_i);
    sys_rst_i = 0;
  endtask
  task automatic t_regs;
    rd(16'hFF42, 8'h00);
    rd(16'hFFF9, 8'h00);
    wr(16'hFF42, 8'h06, 8'hFF);
    rd(16'hFF42, 8'h06);
    rd(16'h1234, 8'h00);
    wr(16'hFF42, 8'h00, 8'hFF);
    $display("regs done");
  endtask
  task automatic t_interval;
    wr(16'hFFF9, 8'h88, 8'hFF);
    wt(3000);
    chk(n > 2030 && n < 2050, 1);
    wt(3000);
    chk(n, 2048);
    wr(16'hFF42, 8'h02, 8'hFF);
    wt(9000);
    wt(9000);
    chk(n, 8192);
    wr(16'hFFF9, 8'h00, 8'hFF);
    rd(16'hFFF9, 8'h88);
    wdt_irq_mask_i = 1;
    wt(8300);
    chk(n, 8300);
    {wdt_irq_mask_i, stop_mode_i} = 2'b01;
    wt(8300);
    chk(n, 8300);
    {stop_mode_i, cpu_on_subclk_i} = 2'b01;
    wt(8300);
    chk(n, 8300);
    cpu_on_subclk_i = 0;
    $display("interval done");
  endtask
  task automatic t_watchdog;
    wr(16'hFF42, 8'h00, 8'hFF);
    wr(16'hFFF9, 8'h10, 8'h10);
    chk(wdt_nmi_req_o, 1);
    repeat (3) begin
      wr(16'hFFF9, 8'h80, 8'h80);
      wt(1500);
      chk(n, 1500);
    end
    wt(2100);
    chk(wdt_reset_req_o, 1);
    rst;
    wr(16'hFFF9, 8'h80, 8'hFF);
    wt(2500);
    chk(n, 2500);
    chk(wdt_irq_flag_i, 0);
    wr(16'hFFF9, 8'h90, 8'hFF);
    chk(wdt_nmi_req_o, 0);
    wt(2500);
    chk(wdt_nmi_req_o, 1);
    $display("watchdog done");
  endtask
  task automatic report_and_stop;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    rst;
    t_regs;
    t_interval;
    t_watchdog;
    report_and_stop;
  end
  initial begin
    repeat (90000) @(negedge clk_i);
    n_errors++;
    report_and_stop;
  end
endmodule // testbench
bind wdtit_top wdtit_properties wdtit_properties_inst (.*);

// file: dv/wdtit_cpu_model.sv
module wdtit_cpu_model (
  input  wire logic clk_i, sys_rst_i, irq_i, nmi_i,
  output logic      flag_o
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) flag_o <= 1'b0;
    else if (irq_i || nmi_i) flag_o <= 1'b1;
  end
endmodule // wdtit_cpu_model

// file: dv/wdtit_properties.sv
module wdtit_properties (
  // Inputs and outputs of the timer
  input wire logic clk_i, sys_rst_i, wr_i, wdt_irq_mask_i, wdt_irq_flag_i, stop_mode_i, cpu_on_subclk_i,
  input wire logic wdt_interval_irq_o, wdt_nmi_req_o, wdt_reset_req_o, running_o,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i, wbit_en_i,
  input wire logic [1:0] mode_o
);
  timeunit 1ns;
  timeprecision 1ps;
  wire mw = wr_i && addr_i == 16'hFFF9;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  reset_zero_a: assert property (disable iff (1'b0) sys_rst_i |=> !mode_o && !running_o) else $error("reset");
  start_go_a: assert property (mw && wdata_i[7] && wbit_en_i[7] && mode_o != 2'h0 |-> ##2
    (running_o || $past(stop_mode_i) || $past(cpu_on_subclk_i))) else $error("start");
  start_sticky_a: assert property (running_o |=> running_o || $past(stop_mode_i) || $past(cpu_on_subclk_i))
    else $error("run lost");
  mode_sticky_a: assert property (!$past(sys_rst_i) |-> (mode_o & $past(mode_o)) == $past(mode_o)) else $error("mode");
  irq_mask_a: assert property (wdt_interval_irq_o |-> mode_o == 2'h1 && !$past(wdt_irq_mask_i)) else $error("irq");
  nmi_mode_a: assert property (wdt_nmi_req_o |-> mode_o[1]) else $error("nmi");
  reset_mode_a: assert property (wdt_reset_req_o |-> mode_o == 2'h3) else $error("rst req");
  nmi_write_a: assert property (mw && wdata_i[4] && wbit_en_i[4] && wdt_irq_flag_i |=> wdt_nmi_req_o) else $error("no nmi");
  frozen_a: assert property ((stop_mode_i || cpu_on_subclk_i) [*2] |-> !wdt_interval_irq_o && !wdt_reset_req_o)
    else $error("frozen");
endmodule // wdtit_properties

// file: hw/wdtit_pkg.sv
package wdtit_pkg;

  // Register addresses on the CPU data space
  localparam logic [15:0] WDTIT_ADDR_CLOCK_SELECT = 16'hFF42;
  localparam logic [15:0] WDTIT_ADDR_MODE_CONTROL = 16'hFFF9;

  // Reset values
  localparam logic [7:0] WDTIT_CLOCK_SELECT_RESET = 8'h00;
  localparam logic [7:0] WDTIT_MODE_CONTROL_RESET = 8'h00;

  // Field positions
  localparam int WDTIT_CLK_SEL_LO_POS      = 1;
  localparam int WDTIT_CLK_SEL_HI_POS      = 2;
  localparam int WDTIT_MODE_ACTION_POS     = 3;
  localparam int WDTIT_MODE_WATCHDOG_POS   = 4;
  localparam int WDTIT_START_POS           = 7;

  // Prescaler and counter sizes
  localparam int WDTIT_PRESCALE_WIDTH      = 10;
  localparam int WDTIT_COUNT_WIDTH         = 7;

  // Prescaler tap positions (divide-by 16, 64, 256, 1024)
  localparam int WDTIT_TAP_DIV16           = 3;
  localparam int WDTIT_TAP_DIV64           = 5;
  localparam int WDTIT_TAP_DIV256          = 7;
  localparam int WDTIT_TAP_DIV1024         = 9;

  // Operation modes
  typedef enum logic [1:0] {
    WDTIT_MODE_STOPPED  = 2'h0,
    WDTIT_MODE_INTERVAL = 2'h1,
    WDTIT_MODE_WDT_NMI  = 2'h2,
    WDTIT_MODE_WDT_RST  = 2'h3
  } wdtit_mode_type;

endpackage : wdtit_pkg

// file: hw/wdtit_prescaler.sv
module wdtit_prescaler
  import wdtit_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  // Control
  input  wire logic       run_i,
  input  wire logic [1:0] clk_sel_i,
  // Count tick
  output logic            tick_o
);

  logic [WDTIT_PRESCALE_WIDTH-1:0] div_count;
  logic [WDTIT_PRESCALE_WIDTH-1:0] next_div_count;
  logic [WDTIT_PRESCALE_WIDTH-1:0] rollover;
  logic                            next_tick;

  // Free divider, never cleared by a restart
  assign next_div_count = run_i ? div_count + 1'b1 : div_count;

  // Tick when the low bits of the selected tap all roll over
  assign rollover = div_count ^ next_div_count;

  always_comb begin
    case (clk_sel_i)
      2'h0:    next_tick = run_i & rollover[WDTIT_TAP_DIV16 + 1];
      2'h1:    next_tick = run_i & rollover[WDTIT_TAP_DIV64 + 1];
      2'h2:    next_tick = run_i & rollover[WDTIT_TAP_DIV256 + 1];
      default: next_tick = run_i & next_div_count == '0 & div_count != '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      div_count <= '0;
      tick_o    <= 1'b0;
    end else begin
      div_count <= next_div_count;
      tick_o    <= next_tick;
    end
  end

endmodule // wdtit_prescaler

// file: hw/wdtit_top.sv
// Operation
// - Select field picks divider and overflow period
// - Both registers read zero after reset
// - Start bit clears counter and starts
// - Start bit only cleared by reset
// - Mode bits are set-only until reset
// - Mode 01 overflow raises interval interrupt
// - Mode 10 overflow raises non-maskable interrupt
// - Mode 11 overflow resets; 00 stays stopped
// - Prescaler kept on restart, first overflow early
// - Pending flag plus watchdog write gives NMI
// - Run in HALT, stop in STOP
// - Stop while CPU uses subsystem clock
// - Interval interrupt masked, top maskable priority
module wdtit_top
  import wdtit_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // CPU data access
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic [7:0]  wbit_en_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [7:0]       rdata_o,
  // CPU power and clock state
  input  wire logic        stop_mode_i,
  input  wire logic        cpu_on_subclk_i,
  // Interrupt controller
  input  wire logic        wdt_irq_mask_i,
  input  wire logic        wdt_irq_flag_i,
  output logic             wdt_interval_irq_o,
  output logic             wdt_nmi_req_o,
  output logic             wdt_reset_req_o,
  // Status
  output logic [1:0]       mode_o,
  output logic             running_o
);

  logic [1:0]                   clk_sel;
  logic                         start_bit;
  logic                         mode_watchdog_bit;
  logic                         mode_action_bit;
  logic [WDTIT_COUNT_WIDTH-1:0] count;
  logic                         tick;

  wire sel_clk_wr  = wr_i & (addr_i == WDTIT_ADDR_CLOCK_SELECT);
  wire sel_mode_wr = wr_i & (addr_i == WDTIT_ADDR_MODE_CONTROL);

  // Mode register bit-level writes only touch enabled bits; clock select write ignores wbit_en_i
  wire set_start    = sel_mode_wr & wbit_en_i[WDTIT_START_POS] & wdata_i[WDTIT_START_POS];
  wire set_watchdog = sel_mode_wr & wbit_en_i[WDTIT_MODE_WATCHDOG_POS] & wdata_i[WDTIT_MODE_WATCHDOG_POS];
  wire set_action   = sel_mode_wr & wbit_en_i[WDTIT_MODE_ACTION_POS] & wdata_i[WDTIT_MODE_ACTION_POS];

  wire [1:0] next_mode = {mode_watchdog_bit | set_watchdog, mode_action_bit | set_action};

  // Counting gated by mode, STOP and subsystem clock
  wire count_en = start_bit & (mode_watchdog_bit | mode_action_bit) &
                  ~stop_mode_i & ~cpu_on_subclk_i;

  wire overflow = count_en & tick & (count == {WDTIT_COUNT_WIDTH{1'b1}});

  wire [7:0] clock_select_rd = {5'h00, clk_sel, 1'b0};
  wire [7:0] mode_control_rd = {start_bit, 2'h0, mode_watchdog_bit, mode_action_bit, 3'h0};

  wire [7:0] next_rdata = !rd_i ? 8'h00 :
                          (addr_i == WDTIT_ADDR_CLOCK_SELECT) ? clock_select_rd :
                          (addr_i == WDTIT_ADDR_MODE_CONTROL) ? mode_control_rd : 8'h00;

  wire irq_interval = overflow & (next_mode == WDTIT_MODE_INTERVAL) & ~wdt_irq_mask_i;
  wire nmi_ovf      = overflow & (next_mode == WDTIT_MODE_WDT_NMI);
  // Write selecting a watchdog mode while flag pending
  wire nmi_pending  = set_watchdog & wdt_irq_flag_i;
  wire rst_ovf      = overflow & (next_mode == WDTIT_MODE_WDT_RST);

  wdtit_prescaler u_prescaler (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .run_i     (count_en),
    .clk_sel_i (clk_sel),
    .tick_o    (tick)
  );

  // Register file
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      clk_sel           <= WDTIT_CLOCK_SELECT_RESET[WDTIT_CLK_SEL_HI_POS:WDTIT_CLK_SEL_LO_POS];
      start_bit         <= WDTIT_MODE_CONTROL_RESET[WDTIT_START_POS];
      mode_watchdog_bit <= WDTIT_MODE_CONTROL_RESET[WDTIT_MODE_WATCHDOG_POS];
      mode_action_bit   <= WDTIT_MODE_CONTROL_RESET[WDTIT_MODE_ACTION_POS];
    end else begin
      if (sel_clk_wr) begin
        clk_sel <= wdata_i[WDTIT_CLK_SEL_HI_POS:WDTIT_CLK_SEL_LO_POS];
      end
      start_bit         <= start_bit | set_start;
      mode_watchdog_bit <= next_mode[1];
      mode_action_bit   <= next_mode[0];
    end
  end

  // Overflow counter, cleared on each start write
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      count <= '0;
    end else if (set_start) begin
      count <= '0;
    end else if (count_en & tick) begin
      count <= count + 1'b1;
    end
  end

  // Outputs
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_o            <= 8'h00;
      wdt_interval_irq_o <= 1'b0;
      wdt_nmi_req_o      <= 1'b0;
      wdt_reset_req_o    <= 1'b0;
      mode_o             <= 2'h0;
      running_o          <= 1'b0;
    end else begin
      rdata_o            <= next_rdata;
      wdt_interval_irq_o <= irq_interval & ~set_start;
      wdt_nmi_req_o      <= (nmi_ovf & ~set_start) | nmi_pending;
      wdt_reset_req_o    <= rst_ovf & ~set_start;
      mode_o             <= next_mode;
      running_o          <= count_en;
    end
  end

endmodule // wdtit_top
